/* File: bench/testbench.sv */
// Self-checking testbench for the clock control block
`timescale 1ns/1ps
module testbench import scgmc_pkg::*;;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic highOscTick = 1'b1;
    logic lowOscTick = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [7:0] regRdData;
    logic gearClkEn, stateClkEn, prescalerClkEn, lowClkSel, quadClkSel, quadRun;
    logic highOscEn, lowOscEn, highOscDrive, lowOscDrive, extClkBuffer, osc2PinHigh;
    logic protectViolationIrq;
    logic [2:0] lowDiv = 3'h0;
    logic lowFast = 1'b0;
    int n_errors = 0;
    int compares = 0;
    int irqCnt = 0;
    scgmc_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .highOscTick(highOscTick),
        .lowOscTick(lowOscTick), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .gearClkEn(gearClkEn), .stateClkEn(stateClkEn), .prescalerClkEn(prescalerClkEn),
        .lowClkSel(lowClkSel), .quadClkSel(quadClkSel), .quadRun(quadRun),
        .highOscEn(highOscEn), .lowOscEn(lowOscEn), .highOscDrive(highOscDrive),
        .lowOscDrive(lowOscDrive), .extClkBuffer(extClkBuffer), .osc2PinHigh(osc2PinHigh),
        .protectViolationIrq(protectViolationIrq));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Low oscillator runs at one eighth of the system clock
    always @(posedge clk_sys) begin
        lowDiv <= lowDiv + 3'h1;
        lowOscTick <= lowFast || (lowDiv == 3'h7);
        if (protectViolationIrq === 1'b1) irqCnt <= irqCnt + 1;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic summarize();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic give_up();
        n_errors++;
        summarize();
    endtask : give_up
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic rst();
        @(posedge clk_sys);
        reset_n <= 1'b0;
        cyc(5);
        reset_n <= 1'b1;
    endtask : rst
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk_sys);
        regWrStb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask : rd
    function automatic logic pick(input int s);
        case (s)
            0: return gearClkEn;
            1: return stateClkEn;
            2: return prescalerClkEn;
            3: return lowClkSel;
            default: return quadClkSel;
        endcase
    endfunction : pick
    // Cycles between two pulses of an enable
    task automatic per(input int s, output int p);
        int n;
        #1 n = 0;
        while (pick(s) !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n >= 100) give_up();
        @(posedge clk_sys);
        #1 p = 1;
        while (pick(s) !== 1'b1 && p < 100) begin
            @(posedge clk_sys);
            #1 p++;
        end
        if (p >= 100) give_up();
    endtask : per
    task automatic wait_sig(input int s, input logic v);
        int n;
        n = 0;
        while (pick(s) !== v && n < 200) begin
            cyc(1);
            #1 n++;
        end
        if (n >= 200) give_up();
    endtask : wait_sig
    // Start a timed operation, see its busy bit high, then see it clear in time
    task automatic timed(input logic [7:0] a, input logic [7:0] d, input int b, input int cnt);
        logic [7:0] x;
        int n;
        wr(a, d);
        cyc(cnt - 12);
        rd(a, x);
        chk({7'h0, x[b]}, 8'h01);
        n = 0;
        while (x[b] !== 1'b0 && n < 20) begin
            rd(a, x);
            n++;
        end
        if (n >= 20) give_up();
        chk({7'h0, x[b]}, 8'h00);
    endtask : timed
    task automatic keys();
        wr(ADDR_KEY_A, KEY_FIRST);
        wr(ADDR_KEY_B, KEY_SECOND);
        wr(ADDR_KEY_A, KEY_SECOND);
        wr(ADDR_KEY_B, KEY_FIRST);
    endtask : keys
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        rd(ADDR_SRC_CTRL0, d); chk(d, RST_SRC_CTRL0);
        rd(ADDR_SEL_GEAR, d); chk(d, RST_SEL_GEAR);
        rd(ADDR_WARMUP_CTRL, d); chk(d, RST_WARMUP_CTRL);
        rd(ADDR_NOISE_CTRL, d); chk(d, RST_NOISE_CTRL);
        rd(ADDR_QUAD_CTRL, d); chk(d, 8'h00);
        rd(ADDR_QUAD_ADJ, d); chk(d, RST_QUAD_ADJ);
        rd(8'h10, d); chk(d, 8'h00);
        chk({highOscDrive, lowOscDrive, extClkBuffer, quadRun, quadClkSel, lowClkSel,
            highOscEn, lowOscEn}, 8'hC3);
    endtask : t_reset
    task automatic t_noise();
        logic [7:0] d;
        wr(ADDR_NOISE_CTRL, 8'h04);
        cyc(2);
        chk({4'h0, highOscDrive, lowOscDrive, extClkBuffer, osc2PinHigh}, 8'h03);
        rd(ADDR_NOISE_CTRL, d); chk(d, 8'h04);
        wr(ADDR_NOISE_CTRL, RST_NOISE_CTRL);
    endtask : t_noise
    task automatic t_gear();
        int p;
        for (int g = 0; g < 5; g++) begin
            wr(ADDR_SEL_GEAR, 8'(g));
            wr(8'h10, 8'h00);
            cyc(100);
            per(0, p); chk(8'(p), 8'(1 << g));
            per(1, p); chk(8'(p), 8'(2 << g));
            per(2, p); chk(8'(p), 8'(2 << g));
        end
        wr(ADDR_SRC_CTRL0, 8'hE2);
        cyc(100);
        per(2, p); chk(8'(p), 8'h20);
        wr(ADDR_SRC_CTRL0, 8'hE0);
    endtask : t_gear
    task automatic t_warm();
        int e[3];
        e = '{WARM_EXP_1, WARM_EXP_2, WARM_EXP_3};
        // Low oscillator ticks every cycle so the long codes stay short
        lowFast <= 1'b1;
        for (int c = 1; c < 4; c++) begin
            wr(ADDR_WARMUP_CTRL, {2'b00, 2'(c), 4'hC});
            timed(ADDR_SRC_CTRL0, 8'hE4, BIT_WARM_RUN, 1 << e[c - 1]);
        end
        lowFast <= 1'b0;
    endtask : t_warm
    task automatic t_source();
        wr(ADDR_WARMUP_CTRL, 8'h1C);
        timed(ADDR_SRC_CTRL0, 8'hE4, BIT_WARM_RUN, 256 * 8);
        wr(ADDR_SEL_GEAR, 8'h0C);
        wait_sig(3, 1'b1); chk({7'h0, lowClkSel}, 8'h01);
        wr(ADDR_SRC_CTRL0, 8'h60);
        cyc(2); chk({6'h0, highOscEn, lowOscEn}, 8'h01);
        timed(ADDR_SRC_CTRL0, 8'hE4, BIT_WARM_RUN, 256);
        wr(ADDR_SEL_GEAR, 8'h04);
        wait_sig(3, 1'b0); chk({7'h0, lowClkSel}, 8'h00);
        wr(ADDR_SRC_CTRL0, 8'hA0);
        cyc(2); chk({6'h0, highOscEn, lowOscEn}, 8'h02);
        wr(ADDR_SRC_CTRL0, 8'hE0);
    endtask : t_source
    task automatic t_quad();
        logic [7:0] d;
        wr(ADDR_QUAD_ADJ, 8'h0B);
        rd(ADDR_QUAD_ADJ, d); chk(d, 8'h0B);
        for (int i = 0; i < 2; i++) begin
            timed(ADDR_QUAD_CTRL, {QUAD_LOCK, 1'b0, 1'(i), 4'h0}, BIT_LOCK_BUSY,
                1 << (i == 1 ? LOCK_EXP_SHORT : LOCK_EXP_LONG));
            chk({7'h0, quadRun}, 8'h01);
            wr(ADDR_QUAD_CTRL, {QUAD_USE, 6'h00});
            wait_sig(4, 1'b1); chk({7'h0, quadClkSel}, 8'h01);
            wr(ADDR_QUAD_CTRL, 8'hC0);
            wait_sig(4, 1'b0); chk({6'h0, quadRun, quadClkSel}, 8'h02);
            wr(ADDR_QUAD_CTRL, 8'h00);
            cyc(2); chk({7'h0, quadRun}, 8'h00);
        end
    endtask : t_quad
    task automatic t_protect();
        logic [7:0] d;
        int k;
        keys();
        rd(ADDR_NOISE_CTRL, d); chk({7'h0, d[BIT_PROT_FLAG]}, 8'h01);
        k = irqCnt;
        wr(ADDR_SEL_GEAR, 8'h00);
        cyc(3); chk(8'(irqCnt - k), 8'h01);
        rd(ADDR_SEL_GEAR, d); chk(d, 8'h04);
        wr(ADDR_NOISE_CTRL, 8'h00);
        rd(ADDR_NOISE_CTRL, d); chk(d, 8'h83);
        wr(ADDR_KEY_A, KEY_FIRST);
        wr(ADDR_KEY_B, KEY_SECOND);
        wr(ADDR_KEY_A, KEY_SECOND);
        wr(ADDR_QUAD_ADJ, 8'h00);
        wr(ADDR_KEY_B, KEY_FIRST);
        rd(ADDR_NOISE_CTRL, d); chk({7'h0, d[BIT_PROT_FLAG]}, 8'h01);
        keys();
        rd(ADDR_NOISE_CTRL, d); chk({7'h0, d[BIT_PROT_FLAG]}, 8'h00);
        keys();
        rst();
        rd(ADDR_NOISE_CTRL, d); chk({7'h0, d[BIT_PROT_FLAG]}, 8'h00);
    endtask : t_protect
    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial begin
        #500000;
        give_up();
    end
    initial begin
        rst();
        t_reset();
        t_noise();
        t_gear();
        t_warm();
        t_source();
        t_quad();
        t_protect();
        summarize();
    end
endmodule : testbench

/* File: core/scgmc_pkg.sv */
// Package of register map, field positions and timing constants for the clock control block
package scgmc_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_SRC_CTRL0 = 8'hE0;
    localparam logic [7:0] ADDR_SEL_GEAR = 8'hE1;
    localparam logic [7:0] ADDR_WARMUP_CTRL = 8'hE2;
    localparam logic [7:0] ADDR_NOISE_CTRL = 8'hE3;
    localparam logic [7:0] ADDR_KEY_A = 8'hE4;
    localparam logic [7:0] ADDR_KEY_B = 8'hE5;
    localparam logic [7:0] ADDR_QUAD_CTRL = 8'hE8;
    localparam logic [7:0] ADDR_QUAD_ADJ = 8'hE9;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_HIGH_EN = 7;
    localparam int BIT_LOW_EN = 6;
    localparam int BIT_WARM_RUN = 2;
    localparam int BIT_CLK_SRC = 3;
    localparam int BIT_LOCK_BUSY = 5;
    localparam int BIT_LOCK_TIME = 4;
    localparam int BIT_PROT_FLAG = 7;
    localparam int BIT_EXT_BUF = 2;
    localparam int BIT_HIGH_DRV = 1;
    localparam int BIT_LOW_DRV = 0;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_SRC_CTRL0 = 8'hE0;
    localparam logic [7:0] RST_SEL_GEAR = 8'h04;
    localparam logic [7:0] RST_WARMUP_CTRL = 8'h2C;
    localparam logic [7:0] RST_NOISE_CTRL = 8'h03;
    localparam logic [7:0] RST_QUAD_ADJ = 8'h13;
    // ----------------------------------------
    // Key values and codes
    // ----------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h5A;
    localparam logic [7:0] KEY_SECOND = 8'hA5;
    localparam logic [1:0] QUAD_STOP = 2'h0;
    localparam logic [1:0] QUAD_LOCK = 2'h1;
    localparam logic [1:0] QUAD_USE = 2'h2;
    // ----------------------------------------
    // Timing exponents of oscillator cycle counts, and gear settle count in gear ticks
    // ----------------------------------------
    localparam int WARM_EXP_1 = 8;
    localparam int WARM_EXP_2 = 14;
    localparam int WARM_EXP_3 = 16;
    localparam int LOCK_EXP_LONG = 12;
    localparam int LOCK_EXP_SHORT = 10;
    localparam int GEAR_SETTLE = 4;
    typedef enum logic [1:0] {
        SCGMC_KEY_IDLE = 2'b00,
        SCGMC_KEY_A1 = 2'b01,
        SCGMC_KEY_ARMED = 2'b10,
        SCGMC_KEY_A2 = 2'b11
    } scgmc_key_t;
endpackage : scgmc_pkg

/* File: core/scgmc_top.sv */
// Clock source, gear, prescaler, quadrupler and protection control
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module scgmc_top import scgmc_pkg::*; #(
    parameter int CNT_W = 17
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Oscillator cycle enables
    input wire logic highOscTick,
    input wire logic lowOscTick,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // Clock enables, oscillator controls and protection violation interrupt
    output logic gearClkEn,
    output logic stateClkEn,
    output logic prescalerClkEn,
    output logic lowClkSel,
    output logic quadClkSel,
    output logic quadRun,
    output logic highOscEn,
    output logic lowOscEn,
    output logic highOscDrive,
    output logic lowOscDrive,
    output logic extClkBuffer,
    output logic osc2PinHigh,
    output logic protectViolationIrq
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] src;
        logic [7:0] selGear;
        logic [7:0] warmCtl;
        logic [7:0] noise;
        logic [7:0] quadAdj;
        logic [1:0] quadAct;
        logic lockTime;
        logic warmBusy;
        logic [CNT_W-1:0] warmCnt;
        logic lockBusy;
        logic [CNT_W-1:0] lockCnt;
        logic [2:0] gearAct;
        logic srcAct;
        logic [2:0] settleCnt;
        logic [3:0] gearDiv;
        logic stateTgl;
        logic [3:0] fc16Div;
        logic preTglA;
        logic preTglB;
        logic prot;
        scgmc_key_t keySt;
        logic [7:0] rdData;
        logic gearEn;
        logic stateEn;
        logic preEn;
        logic irq;
    } scgmc_state_t;

    scgmc_state_t s_q, s_d;

    logic [CNT_W-1:0] warmLimit;
    logic [CNT_W-1:0] lockLimit;
    logic [3:0] gearMask;
    logic gearTick;
    logic protWr;
    logic wrOk;

    always_comb begin
        case (s_q.warmCtl[5:4])
            2'b01: warmLimit = CNT_W'(1 << WARM_EXP_1);
            2'b10: warmLimit = CNT_W'(1 << WARM_EXP_2);
            default: warmLimit = CNT_W'(1 << WARM_EXP_3);
        endcase
        lockLimit = s_q.lockTime ? CNT_W'(1 << LOCK_EXP_SHORT) : CNT_W'(1 << LOCK_EXP_LONG);
        case (s_q.gearAct)
            3'h0: gearMask = 4'h0;
            3'h1: gearMask = 4'h1;
            3'h2: gearMask = 4'h3;
            3'h3: gearMask = 4'h7;
            default: gearMask = 4'hF;
        endcase
    end

    // Warm-up counts the oscillator not in use, the one being brought up
    logic warmTick;
    assign warmTick = s_q.srcAct ? highOscTick : lowOscTick;
    assign gearTick = s_q.srcAct ? lowOscTick
        : (highOscTick && ((s_q.gearDiv & gearMask) == 4'h0));
    assign protWr = regWrStb && (regAddr == ADDR_SRC_CTRL0 || regAddr == ADDR_SEL_GEAR
        || regAddr == ADDR_WARMUP_CTRL || regAddr == ADDR_NOISE_CTRL
        || regAddr == ADDR_QUAD_CTRL || regAddr == ADDR_QUAD_ADJ);
    assign wrOk = regWrStb && !(protWr && s_q.prot);

    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.gearEn = 1'b0;
        s_d.stateEn = 1'b0;
        s_d.preEn = 1'b0;
        // ----------------------------------------
        // Warm-up and lockup timers
        // ----------------------------------------
        if (s_q.warmBusy && warmTick) begin
            if (s_q.warmCnt + CNT_W'(1) >= warmLimit) begin
                s_d.warmBusy = 1'b0;
            end else begin
                s_d.warmCnt = s_q.warmCnt + CNT_W'(1);
            end
        end
        if (s_q.lockBusy && highOscTick) begin
            if (s_q.lockCnt + CNT_W'(1) >= lockLimit) begin
                s_d.lockBusy = 1'b0;
            end else begin
                s_d.lockCnt = s_q.lockCnt + CNT_W'(1);
            end
        end
        // ----------------------------------------
        // Gear, state and prescaler enables
        // ----------------------------------------
        if (highOscTick) begin
            s_d.gearDiv = s_q.gearDiv + 4'h1;
            s_d.fc16Div = s_q.fc16Div + 4'h1;
            if (s_q.fc16Div == 4'hF) begin
                s_d.preTglB = ~s_q.preTglB;
            end
        end
        if (gearTick) begin
            s_d.gearEn = 1'b1;
            s_d.stateTgl = ~s_q.stateTgl;
            s_d.stateEn = s_q.stateTgl;
            s_d.preTglA = ~s_q.preTglA;
            if (s_q.src[1:0] == 2'b00) begin
                s_d.preEn = s_q.preTglA;
            end
            if (s_q.settleCnt != 3'h0) begin
                s_d.settleCnt = s_q.settleCnt - 3'h1;
                if (s_q.settleCnt == 3'h1) begin
                    s_d.gearAct = s_q.selGear[2:0];
                    s_d.gearDiv = 4'h0;
                end
            end
            if (s_q.srcAct != s_q.selGear[BIT_CLK_SRC] && s_q.stateTgl) begin
                s_d.srcAct = s_q.selGear[BIT_CLK_SRC];
                s_d.gearDiv = 4'h0;
            end
        end
        if (s_q.src[1:0] == 2'b10 && highOscTick && s_q.fc16Div == 4'hF && s_q.preTglB) begin
            s_d.preEn = 1'b1;
        end
        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (regWrStb && protWr && s_q.prot) begin
            s_d.irq = 1'b1;
        end
        if (wrOk) begin
            if (regAddr == ADDR_SRC_CTRL0) begin
                s_d.src = regWrData & 8'hFB;
                if (regWrData[BIT_WARM_RUN]) begin
                    s_d.warmBusy = 1'b1;
                    s_d.warmCnt = '0;
                end
            end else if (regAddr == ADDR_SEL_GEAR) begin
                s_d.selGear = regWrData & 8'h0F;
                s_d.settleCnt = 3'(GEAR_SETTLE);
            end else if (regAddr == ADDR_WARMUP_CTRL) begin
                s_d.warmCtl = regWrData;
            end else if (regAddr == ADDR_NOISE_CTRL) begin
                s_d.noise = {1'b0, regWrData[6:0]};
            end else if (regAddr == ADDR_QUAD_CTRL) begin
                s_d.quadAct = regWrData[7:6];
                s_d.lockTime = regWrData[BIT_LOCK_TIME];
                if (regWrData[7:6] == QUAD_LOCK && s_q.quadAct != QUAD_LOCK) begin
                    s_d.lockBusy = 1'b1;
                    s_d.lockCnt = '0;
                end
            end else if (regAddr == ADDR_QUAD_ADJ) begin
                s_d.quadAdj = regWrData;
            end else if (regAddr == ADDR_KEY_A) begin
                s_d.keySt = (regWrData == KEY_FIRST && s_q.keySt == SCGMC_KEY_IDLE) ? SCGMC_KEY_A1
                    : ((regWrData == KEY_SECOND && s_q.keySt == SCGMC_KEY_ARMED) ? SCGMC_KEY_A2
                    : SCGMC_KEY_IDLE);
            end else if (regAddr == ADDR_KEY_B) begin
                case (s_q.keySt)
                    SCGMC_KEY_A1: begin
                        s_d.keySt = (regWrData == KEY_SECOND) ? SCGMC_KEY_ARMED : SCGMC_KEY_IDLE;
                    end
                    SCGMC_KEY_A2: begin
                        s_d.keySt = SCGMC_KEY_IDLE;
                        if (regWrData == KEY_FIRST) begin
                            s_d.prot = ~s_q.prot;
                        end
                    end
                    default: begin
                        s_d.keySt = SCGMC_KEY_IDLE;
                    end
                endcase
            end
        end
        // Any other write, even a blocked one, breaks the key sequence
        if (regWrStb && regAddr != ADDR_KEY_A && regAddr != ADDR_KEY_B
            && s_q.keySt != SCGMC_KEY_IDLE) begin
            s_d.keySt = SCGMC_KEY_IDLE;
        end
        // ----------------------------------------
        // Register reads
        // ----------------------------------------
        s_d.rdData = 8'h00;
        if (regRdStb) begin
            if (regAddr == ADDR_SRC_CTRL0) begin
                s_d.rdData = {s_q.src[7:3], s_q.warmBusy, s_q.src[1:0]};
            end else if (regAddr == ADDR_SEL_GEAR) begin
                s_d.rdData = s_q.selGear;
            end else if (regAddr == ADDR_WARMUP_CTRL) begin
                s_d.rdData = s_q.warmCtl;
            end else if (regAddr == ADDR_NOISE_CTRL) begin
                s_d.rdData = {s_q.prot, s_q.noise[6:0]};
            end else if (regAddr == ADDR_QUAD_CTRL) begin
                s_d.rdData = {s_q.quadAct, s_q.lockBusy, s_q.lockTime, 4'h0};
            end else if (regAddr == ADDR_QUAD_ADJ) begin
                s_d.rdData = s_q.quadAdj;
            end else begin
                s_d.rdData = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.src <= RST_SRC_CTRL0;
            s_q.selGear <= RST_SEL_GEAR;
            s_q.warmCtl <= RST_WARMUP_CTRL;
            s_q.noise <= RST_NOISE_CTRL;
            s_q.quadAdj <= RST_QUAD_ADJ;
            s_q.quadAct <= QUAD_STOP;
            s_q.gearAct <= RST_SEL_GEAR[2:0];
            s_q.keySt <= SCGMC_KEY_IDLE;
            s_q.prot <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign regRdData = s_q.rdData;
    assign gearClkEn = s_q.gearEn;
    assign stateClkEn = s_q.stateEn;
    assign prescalerClkEn = s_q.preEn;
    assign lowClkSel = s_q.srcAct;
    assign quadClkSel = (s_q.quadAct == QUAD_USE);
    assign quadRun = (s_q.quadAct != QUAD_STOP);
    assign highOscEn = s_q.src[BIT_HIGH_EN];
    assign lowOscEn = s_q.src[BIT_LOW_EN];
    assign highOscDrive = s_q.noise[BIT_HIGH_DRV];
    assign lowOscDrive = s_q.noise[BIT_LOW_DRV];
    assign extClkBuffer = s_q.noise[BIT_EXT_BUF];
    assign osc2PinHigh = s_q.noise[BIT_EXT_BUF];
    assign protectViolationIrq = s_q.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    warm_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrOk && regAddr == ADDR_SRC_CTRL0 && regWrData[BIT_WARM_RUN] |=> s_q.warmBusy)
        else $error("warm-up did not start");
    warm_short_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_q.warmBusy && s_q.warmCtl[5:4] == 2'b01 |-> s_q.warmCnt < CNT_W'(256))
        else $error("warm-up count exceeds short limit");
    lock_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrOk && regAddr == ADDR_QUAD_CTRL && regWrData[7:6] == QUAD_LOCK
        && s_q.quadAct == QUAD_STOP |=> s_q.lockBusy)
        else $error("lockup flag not raised");
    prot_block_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_q.prot && regWrStb && regAddr == ADDR_NOISE_CTRL |=> $stable(s_q.noise)
        && protectViolationIrq)
        else $error("protected write not blocked");
    prot_toggle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $changed(s_q.prot) |-> $past(s_q.keySt) == SCGMC_KEY_A2)
        else $error("protection changed without key");
    ext_pin_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        extClkBuffer |-> osc2PinHigh)
        else $error("second pin not high in buffer mode");
    gear_settle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrOk && regAddr == ADDR_SEL_GEAR |=> s_q.settleCnt == 3'(GEAR_SETTLE))
        else $error("gear settle not armed");
    state_half_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        stateClkEn |-> !$past(s_q.stateTgl, 1) == 1'b0)
        else $error("state enable off phase");
    lock_bound_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_q.lockBusy |-> s_q.lockCnt < CNT_W'(1 << LOCK_EXP_LONG))
        else $error("lockup count beyond long limit");
    reset_prot_a: assert property (@(posedge clk_sys)
        !reset_n |=> !s_q.prot)
        else $error("protection on after reset");
    reset_drive_a: assert property (@(posedge clk_sys)
        !reset_n |=> highOscDrive && lowOscDrive && !extClkBuffer)
        else $error("noise bits wrong after reset");
    state_gap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        stateClkEn |=> !stateClkEn)
        else $error("state enable on two cycles in a row");
    irq_cause_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        protectViolationIrq |-> $past(s_q.prot))
        else $error("violation pulse without protection");
    src_edge_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $changed(lowClkSel) && $past(reset_n) |-> stateClkEn)
        else $error("source switched off a state boundary");
    high_weak_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrOk && regAddr == ADDR_NOISE_CTRL && !regWrData[BIT_HIGH_DRV] |=> !highOscDrive)
        else $error("high drive not reduced");
    low_weak_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrOk && regAddr == ADDR_NOISE_CTRL && !regWrData[BIT_LOW_DRV] |=> !lowOscDrive)
        else $error("low drive not reduced");
endmodule : scgmc_top
